/* dual_comparator_status_irq.sv */
// Purpose: Register bank and interrupt flags around two analog comparators
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   Analog levels are synchronised before any use
// What this block does
// - Window state reported as 00/01/10/11 codes
// - Status bit 5 tracks comparator one
// - Status bit 4 tracks comparator zero
// - Window flag set on selected condition
// - Window flag cleared on vector acknowledge
// - Comparator one flag set on edge
// - Comparator one flag cleared on vector
// - Comparator zero flag set on edge
// - Comparator zero flag cleared on vector
// - Write one clears flag, zero keeps
// - Status bit 3 reads zero always
// - Control bit 7 enables current source
// - Control bit 6 combines both sources
// - Bits 1:0 route source per comparator
// - Four-bit trim drives source, upper zero
// - Vectors at offsets 0x00, 0x02, 0x04
// - Edge condition toggle, falling, rising select
// - Window condition above/inside/below/outside select
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "dual_cmp_regs.svh"

module dual_comparator_status_irq
   import dual_cmp_pkg::*;
(
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // AHB-Lite slave
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic      [31:0]  hrdata,
   output logic              hreadyout,
   output logic              hresp,
   // Analog comparator side
   input  wire analog_in_t   analog_in,
   output source_ctrl_t      source_ctrl,
   output logic [2:0]        cmp0_negative_input_select,
   output logic [2:0]        cmp1_negative_input_select,
   // Interrupt controller side
   output irq_req_t          irq_req,
   output logic [7:0]        irq_vector,
   input  wire logic         vector_ack
);

   // Bus decode
   logic              addr_phase;
   logic              wr_pend_ff;
   logic [3:0]        idx_ff;
   logic [3:0]        haddr_idx;
   logic              addr_ok;
   logic [7:0]        wdata;
   logic              wr_en;
   bus_phase_t        phase_ff;
   logic [7:0]        reg_rd;

   // Register storage
   logic [7:0]        cmp_ctrl_ff [2];
   logic [7:0]        cmp_insel_ff [2];
   logic [7:0]        invert_ctrl_ff;
   logic [7:0]        scaler_ctrl_ff;
   logic [7:0]        window_ctrl_ff;
   logic [7:0]        source_ctrl_ff;
   logic [7:0]        source_trim_ff;

   // Synchronisers and flags
   analog_in_t        sync1_ff;
   analog_in_t        sync2_ff;
   analog_in_t        prev_ff;
   logic [2:0]        flag_ff;
   logic [2:0]        set_ev;
   logic [2:0]        sw_clr;
   logic [2:0]        vec_clr;
   logic [2:0]        nxt_flag;
   logic [1:0]        cmp_now;
   logic [1:0]        cmp_was;
   logic [1:0]        win_cond;
   logic              win_enter;

   assign addr_phase = hsel && hready && htrans[1];
   assign haddr_idx  = haddr[5:2];
   assign addr_ok    = (haddr[31:6] == 26'h0) && (haddr_idx <= `IDX_LAST);
   assign wdata      = hwdata[7:0];
   assign wr_en      = wr_pend_ff;

   // Zero wait state slave; unmapped offsets read zero and ignore writes
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         idx_ff     <= 4'h0;
         phase_ff   <= PH_IDLE;
      end else begin
         wr_pend_ff <= addr_phase && hwrite && addr_ok;
         idx_ff     <= haddr_idx;
         if (addr_phase && addr_ok) begin
            phase_ff <= hwrite ? PH_WRITE : PH_READ;
         end else begin
            phase_ff <= PH_IDLE;
         end
      end
   end

   // Read data registered at address phase so data comes from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (addr_phase) begin
         hrdata <= (addr_ok && !hwrite) ? {24'h0, reg_rd} : 32'h0;
      end
   end

   // Per-comparator control registers
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               cmp_ctrl_ff[gi]  <= `REG_RESET;
               cmp_insel_ff[gi] <= `REG_RESET;
            end else if (wr_en) begin
               if (idx_ff == `IDX_CMP0_CTRL + 4'(gi)) begin
                  cmp_ctrl_ff[gi] <= wdata & `MASK_CMP_CTRL;
               end
               if (idx_ff == `IDX_CMP0_INSEL + 4'(gi)) begin
                  cmp_insel_ff[gi] <= wdata & `MASK_CMP_INSEL;
               end
            end
         end
      end
   endgenerate

   // Shared control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         invert_ctrl_ff <= `REG_RESET;
         scaler_ctrl_ff <= `REG_RESET;
         window_ctrl_ff <= `REG_RESET;
         source_ctrl_ff <= `REG_RESET;
         source_trim_ff <= `REG_RESET;
      end else if (wr_en) begin
         unique case (idx_ff)
            `IDX_INVERT_CTRL: invert_ctrl_ff <= wdata & `MASK_INVERT_CTRL;
            `IDX_SCALER_CTRL: scaler_ctrl_ff <= wdata & `MASK_SCALER_CTRL;
            `IDX_WINDOW_CTRL: window_ctrl_ff <= wdata & `MASK_WINDOW_CTRL;
            `IDX_SOURCE_CTRL: source_ctrl_ff <= wdata & `MASK_SOURCE_CTRL;
            `IDX_SOURCE_TRIM: source_trim_ff <= wdata & `MASK_SOURCE_TRIM;
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff  <= '0;
      end else begin
         sync1_ff <= analog_in;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   assign cmp_now = {sync2_ff.cmp1_level, sync2_ff.cmp0_level};
   assign cmp_was = {prev_ff.cmp1_level, prev_ff.cmp0_level};

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         unique case (cmp_ctrl_ff[i][`POS_EDGE_COND_HI:`POS_EDGE_COND_LO])
            `EDGE_TOGGLE:  set_ev[i] = cmp_now[i] ^ cmp_was[i];
            `EDGE_FALLING: set_ev[i] = cmp_was[i] && !cmp_now[i];
            `EDGE_RISING:  set_ev[i] = cmp_now[i] && !cmp_was[i];
            default:       set_ev[i] = 1'b0; // Reserved code never sets
         endcase
         if (!cmp_ctrl_ff[i][`POS_CMP_ENABLE]) begin
            set_ev[i] = 1'b0;
         end
      end
   end

   always_comb begin
      win_cond = window_ctrl_ff[`POS_WIN_COND_HI:`POS_WIN_COND_LO];
      unique case (win_cond)
         `WIN_ABOVE:   win_enter = sync2_ff.window_state == `WIN_ABOVE;
         `WIN_INSIDE:  win_enter = sync2_ff.window_state == `WIN_INSIDE;
         `WIN_BELOW:   win_enter = sync2_ff.window_state == `WIN_BELOW;
         `WIN_OUTSIDE: win_enter = sync2_ff.window_state == `WIN_OUTSIDE
                                   || sync2_ff.window_state == `WIN_ABOVE
                                   || sync2_ff.window_state == `WIN_BELOW;
      endcase
   end

   // window flag set, gated by window enable
   assign set_ev[2] = window_ctrl_ff[`POS_WIN_ENABLE] && win_enter;

   assign sw_clr = (wr_en && idx_ff == `IDX_STATUS)
                   ? wdata[`POS_ST_WIN_IF:`POS_ST_CMP0_IF] : 3'b000;

   always_comb begin
      vec_clr = 3'b000;
      if (vector_ack) begin
         unique case (irq_vector)
            `VEC_CMP0:   vec_clr = 3'b001;
            `VEC_CMP1:   vec_clr = 3'b010;
            `VEC_WINDOW: vec_clr = 3'b100;
            default:     vec_clr = 3'b000;
         endcase
      end
   end

   assign nxt_flag = set_ev | (flag_ff & ~(sw_clr | vec_clr));

   // Interrupt flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_ff <= 3'b000;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   // Requests gated by each source's nonzero interrupt level
   always_comb begin
      irq_req.cmp0_irq   = flag_ff[0] &&
         (cmp_ctrl_ff[0][`POS_IRQ_LVL_HI:`POS_IRQ_LVL_LO] != 2'h0);
      irq_req.cmp1_irq   = flag_ff[1] &&
         (cmp_ctrl_ff[1][`POS_IRQ_LVL_HI:`POS_IRQ_LVL_LO] != 2'h0);
      irq_req.window_irq = flag_ff[2] &&
         (window_ctrl_ff[`POS_WIN_LEVEL_HI:`POS_WIN_LEVEL_LO] != 2'h0);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_vector <= `VEC_CMP0;
      end else if (irq_req.cmp0_irq) begin
         irq_vector <= `VEC_CMP0;
      end else if (irq_req.cmp1_irq) begin
         irq_vector <= `VEC_CMP1;
      end else if (irq_req.window_irq) begin
         irq_vector <= `VEC_WINDOW;
      end
   end

   // Register read mux
   always_comb begin
      reg_rd = 8'h00;
      unique case (haddr_idx)
         `IDX_CMP0_CTRL:   reg_rd = cmp_ctrl_ff[0];
         `IDX_CMP1_CTRL:   reg_rd = cmp_ctrl_ff[1];
         `IDX_CMP0_INSEL:  reg_rd = cmp_insel_ff[0];
         `IDX_CMP1_INSEL:  reg_rd = cmp_insel_ff[1];
         `IDX_INVERT_CTRL: reg_rd = invert_ctrl_ff;
         `IDX_SCALER_CTRL: reg_rd = scaler_ctrl_ff;
         `IDX_WINDOW_CTRL: reg_rd = window_ctrl_ff;
         `IDX_STATUS: begin
            // window state code in top bits
            reg_rd[`POS_ST_WINDOW_STATE_HI:`POS_ST_WINDOW_STATE_LO] =
               window_ctrl_ff[`POS_WIN_ENABLE] ? sync2_ff.window_state : 2'h0;
            reg_rd[`POS_ST_CMP1] = sync2_ff.cmp1_level;
            reg_rd[`POS_ST_CMP0] = sync2_ff.cmp0_level;
            reg_rd[`POS_ST_RSVD] = 1'b0;
            reg_rd[`POS_ST_WIN_IF:`POS_ST_CMP0_IF] = flag_ff;
         end
         `IDX_SOURCE_CTRL: reg_rd = source_ctrl_ff;
         `IDX_SOURCE_TRIM: reg_rd = source_trim_ff;
         default:          reg_rd = 8'h00;
      endcase
   end

   // Analog controls straight from registers
   always_comb begin
      source_ctrl.source_enable      = source_ctrl_ff[`POS_SRC_ENABLE];
      source_ctrl.combine_sources    = source_ctrl_ff[`POS_SRC_COMBINE];
      source_ctrl.cmp1_source_out_en = source_ctrl_ff[`POS_SRC_OUT1];
      source_ctrl.cmp0_source_out_en = source_ctrl_ff[`POS_SRC_OUT0];
      source_ctrl.source_trim        = source_trim_ff[`POS_TRIM_HI:`POS_TRIM_LO];
   end

   assign cmp0_negative_input_select = cmp_insel_ff[0][`POS_NEG_SEL_HI:`POS_NEG_SEL_LO];
   assign cmp1_negative_input_select = cmp_insel_ff[1][`POS_NEG_SEL_HI:`POS_NEG_SEL_LO];

endmodule : dual_comparator_status_irq
`default_nettype wire

/* dual_cmp_regs.svh */
// Purpose: Register map, field positions and reset values of the comparator block
// Assumes: Word offsets are register indices; byte address is four times the index
// Notes:   Definitions only
`ifndef DUAL_CMP_REGS_SVH
`define DUAL_CMP_REGS_SVH

// Register indices
`define IDX_CMP0_CTRL      4'h0
`define IDX_CMP1_CTRL      4'h1
`define IDX_CMP0_INSEL     4'h2
`define IDX_CMP1_INSEL     4'h3
`define IDX_INVERT_CTRL    4'h4
`define IDX_SCALER_CTRL    4'h5
`define IDX_WINDOW_CTRL    4'h6
`define IDX_STATUS         4'h7
`define IDX_SOURCE_CTRL    4'h8
`define IDX_SOURCE_TRIM    4'h9
`define IDX_VEC_ACK        4'hA
`define IDX_LAST           4'hA

// Reset value shared by all registers
`define REG_RESET          8'h00

// Writable masks per register
`define MASK_CMP_CTRL      8'hF7
`define MASK_CMP_INSEL     8'h3F
`define MASK_INVERT_CTRL   8'h0F
`define MASK_SCALER_CTRL   8'h3F
`define MASK_WINDOW_CTRL   8'h1F
`define MASK_SOURCE_CTRL   8'hC3
`define MASK_SOURCE_TRIM   8'h0F

// Field positions
`define POS_EDGE_COND_HI   7
`define POS_EDGE_COND_LO   6
`define POS_CMP_ENABLE     0
`define POS_IRQ_LVL_HI     5
`define POS_IRQ_LVL_LO     4
`define POS_WIN_ENABLE     4
`define POS_WIN_COND_HI    3
`define POS_WIN_COND_LO    2
`define POS_WIN_LEVEL_HI   1
`define POS_WIN_LEVEL_LO   0
`define POS_NEG_SEL_HI     2
`define POS_NEG_SEL_LO     0
`define POS_SRC_ENABLE     7
`define POS_SRC_COMBINE    6
`define POS_SRC_OUT1       1
`define POS_SRC_OUT0       0
`define POS_TRIM_HI        3
`define POS_TRIM_LO        0
`define POS_ST_WINDOW_STATE_HI   7
`define POS_ST_WINDOW_STATE_LO   6
`define POS_ST_CMP1        5
`define POS_ST_CMP0        4
`define POS_ST_RSVD        3
`define POS_ST_WIN_IF      2
`define POS_ST_CMP1_IF     1
`define POS_ST_CMP0_IF     0

// Interrupt vector offsets
`define VEC_CMP0           8'h00
`define VEC_CMP1           8'h02
`define VEC_WINDOW         8'h04

// Window state codes
`define WIN_ABOVE          2'h0
`define WIN_INSIDE         2'h1
`define WIN_BELOW          2'h2
`define WIN_OUTSIDE        2'h3

// Edge condition codes
`define EDGE_TOGGLE        2'h0
`define EDGE_FALLING       2'h2
`define EDGE_RISING        2'h3

`endif

/* dual_cmp_pkg.sv */
// Purpose: Types shared by the comparator register block
// Assumes: Constants live in dual_cmp_regs.svh
// Notes:   Types only
package dual_cmp_pkg;

   // Analog inputs grouped as one carrier
   typedef struct packed {
      logic [1:0] window_state;
      logic       cmp1_level;
      logic       cmp0_level;
   } analog_in_t;

   // Controls driven to the analog current source
   typedef struct packed {
      logic       source_enable;
      logic       combine_sources;
      logic       cmp1_source_out_en;
      logic       cmp0_source_out_en;
      logic [3:0] source_trim;
   } source_ctrl_t;

   // Interrupt request outputs
   typedef struct packed {
      logic window_irq;
      logic cmp1_irq;
      logic cmp0_irq;
   } irq_req_t;

   // Bus data phase state
   typedef enum logic [1:0] {
      PH_IDLE,
      PH_WRITE,
      PH_READ
   } bus_phase_t;

endpackage : dual_cmp_pkg

/* dual_cmp_props.sv */
// Purpose: Port checks for the comparator register block
// Assumes: Zero wait bus; read data stands in the data phase
// Notes:   Bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none

module dual_cmp_props
   import dual_cmp_pkg::*;
(
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Bus
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic         hready,
   input  wire logic [31:0]  hrdata,
   // Analog and interrupt side
   input  wire analog_in_t   analog_in,
   input  wire source_ctrl_t source_ctrl,
   input  wire irq_req_t     irq_req,
   input  wire logic [7:0]   irq_vector,
   input  wire logic         vector_ack
);
   logic        rd_ff;
   logic [3:0]  idx_ff;
   logic [15:0] hist_ff;
   logic        quiet;

   // Taken read and its index, judged in its data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ff  <= 1'b0;
         idx_ff <= 4'h0;
      end else begin
         rd_ff  <= hsel && hready && htrans[1] && !hwrite && haddr[31:6] == 26'h0;
         idx_ff <= haddr[5:2];
      end
   end

   // Four past samples; synchronisers are settled once these agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hist_ff <= 16'h0000;
      else
         hist_ff <= {hist_ff[11:0], analog_in};
   end
   assign quiet = hist_ff == {4{analog_in}};

   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   rsvd_bit_a: assert property (rd_ff && idx_ff == 4'h7 |-> !hrdata[3])
      else $error("status bit 3 read as one");
   trim_read_a: assert property (rd_ff && idx_ff == 4'h9 |->
      hrdata == {28'h0, source_ctrl.source_trim}) else $error("trim mismatch");
   src_read_a: assert property (rd_ff && idx_ff == 4'h8 |->
      hrdata == {24'h0, source_ctrl[7:6], 4'h0, source_ctrl[5:4]})
      else $error("source control mismatch");
   live_level_a: assert property (rd_ff && idx_ff == 4'h7 && quiet |->
      hrdata[5:4] == analog_in[1:0]) else $error("status level mismatch");
   vec_code_a: assert property (irq_vector inside {8'h00, 8'h02, 8'h04})
      else $error("bad vector code");
   vec_prio_a: assert property (irq_req.cmp0_irq [*2] |-> irq_vector == 8'h00)
      else $error("vector not comparator zero");
   win_vec_a: assert property ((irq_req == 3'b100) [*2] |-> irq_vector == 8'h04)
      else $error("vector not window");
   ack_clear_a: assert property (vector_ack && irq_vector == 8'h00 &&
      irq_req.cmp0_irq && quiet |=> !irq_req.cmp0_irq) else $error("ack kept flag");
endmodule : dual_cmp_props

bind dual_comparator_status_irq dual_cmp_props dual_cmp_props_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .analog_in(analog_in),
   .source_ctrl(source_ctrl), .irq_req(irq_req), .irq_vector(irq_vector),
   .vector_ack(vector_ack));
`default_nettype wire

/* dual_cmp_partner.sv */
// Purpose: Analog cores and interrupt controller beside the block
// Assumes: Bench commands levels and acknowledge pacing
// Notes:   Acknowledge wait is adjustable, prompt or slow
`timescale 1ns/1ns
`default_nettype none

module dual_cmp_partner
   import dual_cmp_pkg::*;
(
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Bench commands
   input  wire analog_in_t level_cmd,
   input  wire logic       ack_en,
   input  wire logic [3:0] ack_wait,
   // Block side
   output wire analog_in_t analog_in,
   input  wire irq_req_t   irq_req,
   output logic            vector_ack
);
   logic [3:0] cnt_ff;

   // Analog levels move 1 ns after each command change, off the clock edge
   assign #1 analog_in = level_cmd;

   // one-cycle acknowledge
   // Two extra cycles let the registered vector settle first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff     <= 4'h0;
         vector_ack <= 1'b0;
      end else if (vector_ack || !ack_en || irq_req == 3'b000) begin
         cnt_ff     <= 4'h0;
         vector_ack <= 1'b0;
      end else begin
         cnt_ff     <= cnt_ff + 4'h1;
         vector_ack <= cnt_ff == ack_wait + 4'h2;
      end
   end
endmodule : dual_cmp_partner
`default_nettype wire

/* dual_comparator_status_irq_tb.sv */
// Purpose: Self-checking bench for the comparator register block
// Assumes: Zero wait bus; partner drives levels and acknowledges
// Notes:   Expectations come from the register map alone
`timescale 1ns/1ns
`default_nettype none

module dual_comparator_status_irq_tb
   import dual_cmp_pkg::*;
;
   logic         hclk = 1'b0;
   logic         hresetn, hsel, hwrite, hreadyout, hresp, ack_en, vector_ack;
   logic [1:0]   htrans;
   logic [2:0]   neg0, neg1;
   logic [3:0]   ack_wait;
   logic [7:0]   irq_vector;
   logic [31:0]  haddr, hwdata, hrdata;
   source_ctrl_t source_ctrl;
   irq_req_t     irq_req;
   analog_in_t   level_cmd;
   wire analog_in_t analog_in;
   int           err_total = 0;
   int           n_compared = 0;

   dual_comparator_status_irq dual_comparator_status_irq_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .analog_in(analog_in),
      .source_ctrl(source_ctrl), .cmp0_negative_input_select(neg0),
      .cmp1_negative_input_select(neg1), .irq_req(irq_req), .irq_vector(irq_vector),
      .vector_ack(vector_ack));

   dual_cmp_partner dual_cmp_partner_inst (
      .hclk(hclk), .hresetn(hresetn), .level_cmd(level_cmd), .ack_en(ack_en),
      .ack_wait(ack_wait), .analog_in(analog_in), .irq_req(irq_req),
      .vector_ack(vector_ack));

   // 250 MHz clock
   always #2 hclk = ~hclk;

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Single word transfer; holds each phase until ready is seen
   task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {26'h0, idx, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer

   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      logic [31:0] x;
      xfer(1'b1, i, d, x);
   endtask : wr

   task automatic rchk(input logic [3:0] i, input logic [7:0] e);
      logic [31:0] x;
      xfer(1'b0, i, 8'h00, x);
      chk(x, {24'h0, e});
   endtask : rchk

   // Reset values, masks, outputs and unmapped places
   task automatic t_regs;
      for (int i = 0; i < 16; i++)
         rchk(i[3:0], 8'h00);
      chk(source_ctrl, 32'h0);
      chk({hreadyout, hresp}, 32'h2);
      wr(4'h8, 8'hFF);
      rchk(4'h8, 8'hC3);
      wr(4'h9, 8'hFF);
      rchk(4'h9, 8'h0F);
      chk(source_ctrl, 32'hFF);
      wr(4'h8, 8'h41);
      rchk(4'h8, 8'h41);
      chk(source_ctrl, 32'h5F);
      wr(4'h2, 8'h3D);
      wr(4'h3, 8'h3A);
      rchk(4'h3, 8'h3A);
      chk({neg1, neg0}, 32'h15);
      // reserved status bit written as zero
      wr(4'h7, 8'hF7);
      rchk(4'h7, 8'h00);
      wr(4'hF, 8'hFF);
      rchk(4'hF, 8'h00);
      $display("t_regs done");
   endtask : t_regs

   // Every edge code on both comparators; tables say which codes set
   task automatic t_edges;
      logic [3:0] rise = 4'b1001;
      logic [3:0] fall = 4'b0101;
      for (int c = 0; c < 2; c++) begin
         for (int m = 0; m < 4; m++) begin
            wr(c[3:0], {m[1:0], 6'h01});
            wr(4'h7, 8'h07);
            level_cmd[c] <= 1'b1;
            cyc(4);
            wr(4'h7, 8'h00);
            rchk(4'h7, (8'h10 << c) | (rise[m] ? 8'h01 << c : 8'h00));
            wr(4'h7, 8'h01 << c);
            rchk(4'h7, 8'h10 << c);
            level_cmd[c] <= 1'b0;
            cyc(4);
            rchk(4'h7, fall[m] ? 8'h01 << c : 8'h00);
         end
      end
      $display("t_edges done");
   endtask : t_edges

   // Each window state against a condition it cannot meet, then its own
   task automatic t_window;
      for (int s = 0; s < 4; s++) begin
         level_cmd.window_state <= s[1:0];
         wr(4'h6, {3'b001, 1'b0, ~s[0], 2'b00});
         wr(4'h7, 8'h04);
         rchk(4'h7, {s[1:0], 6'h00});
         wr(4'h6, {3'b001, s[1:0], 2'b00});
         cyc(1); // Flag lands one edge after the condition write
         rchk(4'h7, {s[1:0], 6'h04});
      end
      wr(4'h6, 8'h00);
      wr(4'h7, 8'h04);
      rchk(4'h7, 8'h00);
      $display("t_window done");
   endtask : t_window

   // Three pending requests taken in priority order by the controller
   task automatic t_vectors;
      logic [7:0] vec [3] = '{8'h00, 8'h02, 8'h04};
      level_cmd.window_state <= 2'b01;
      wr(4'h0, 8'h31);
      wr(4'h1, 8'h31);
      wr(4'h6, 8'h15);
      level_cmd[1:0] <= 2'b11;
      cyc(4);
      level_cmd.window_state <= 2'b00;
      cyc(4);
      chk(irq_req, 32'h7);
      chk(irq_vector, 32'h0);
      ack_en <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         do @(posedge hclk); while (vector_ack !== 1'b1);
         chk(irq_vector, {24'h0, vec[k]});
      end
      cyc(3);
      chk(irq_req, 32'h0);
      ack_en <= 1'b0;
      $display("t_vectors done");
   endtask : t_vectors

   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   // Main sequence after an eight cycle reset
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0;
      hwdata = 32'h0;
      level_cmd = 4'h0;
      ack_en = 1'b0;
      ack_wait = 4'h3;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_edges();
      t_window();
      t_vectors();
      print_verdict();
   end

   // Tests take well under a thousand cycles; this cuts a hang short
   initial begin
      #20000;
      err_total++;
      $display("ERROR %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule : dual_comparator_status_irq_tb
`default_nettype wire
